// File: gma_pkg.sv
// Purpose: Shared constants and types for the graphics memory allocator
// Assumes: Byte counts fit in 16 bits; five buffers in fixed order
// Notes: Buffer order is physical I/O, polygon, glyph, replot, vector

package gma_pkg;

	// ----------
	// Buffer indices and widths
	// ----------
	localparam int NBUF = 5;
	localparam int SIZE_W = 16;
	localparam int SUM_W = 19;
	localparam logic [2:0] BUF_PHYS = 3'h0;
	localparam logic [2:0] BUF_POLY = 3'h1;
	localparam logic [2:0] BUF_GLYPH = 3'h2;
	localparam logic [2:0] BUF_REPLOT = 3'h3;
	localparam logic [2:0] BUF_VEC = 3'h4;

	// ----------
	// Memory total, reset sizes and minimums
	// ----------
	localparam logic [15:0] MEM_TOTAL = 16'h3200;
	localparam logic [15:0] RST_PHYS = 16'h0400;
	localparam logic [15:0] RST_POLY = 16'h06F2;
	localparam logic [15:0] RST_GLYPH = 16'h0000;
	localparam logic [15:0] RST_REPLOT = 16'h26E2;
	localparam logic [15:0] RST_VEC = 16'h002C;
	localparam logic [15:0] MIN_PHYS = 16'h0002;
	localparam logic [15:0] MIN_POLY = 16'h0000;
	localparam logic [15:0] MIN_GLYPH_NONE = 16'h0000;
	localparam logic [15:0] MIN_GLYPH_USED = 16'h01C4;
	localparam logic [15:0] MIN_REPLOT = 16'h0000;
	localparam logic [15:0] MIN_VEC = 16'h002C;

	// ----------
	// Logical input-buffer size
	// ----------
	localparam logic [15:0] LOG_RST = 16'h0400;
	localparam logic [15:0] LOG_MIN = 16'h0002;
	localparam logic [15:0] LOG_MAX = 16'h31D0;

	// ----------
	// Error, status and reply encoding
	// ----------
	localparam logic [3:0] ERR_NONE = 4'h0;
	localparam logic [3:0] ERR_OVERFLOW = 4'h7;
	localparam int STAT_IN_EMPTY_BIT = 3;
	localparam logic [7:0] ASCII_ZERO = 8'h30;
	localparam logic [7:0] REPLY_TERM = 8'h0D;
	localparam logic [15:0] DEC_POW4 = 16'h2710;
	localparam logic [15:0] DEC_POW3 = 16'h03E8;
	localparam logic [15:0] DEC_POW2 = 16'h0064;
	localparam logic [15:0] DEC_POW1 = 16'h000A;
	localparam logic [15:0] DEC_POW0 = 16'h0001;
	localparam logic [2:0] DEC_TOP_POS = 3'h4;

	// ----------
	// State types
	// ----------
	typedef enum logic [2:0] {
		GMA_IDLE = 3'b000,
		GMA_FLUSH = 3'b001,
		GMA_WAIT_VEC = 3'b010,
		GMA_TRIM = 3'b011,
		GMA_CLEAR = 3'b100,
		GMA_PARSER_RST = 3'b101
	} gma_alloc_state_type;

	typedef enum logic [1:0] {
		GMA_EM_IDLE = 2'b00,
		GMA_EM_DIV = 2'b01,
		GMA_EM_SEND = 2'b10,
		GMA_EM_TERM = 2'b11
	} gma_emit_state_type;

endpackage

// File: gma_dec_emit.sv
// Purpose: Sends a 16-bit value as ASCII decimal digits plus terminator
// Assumes: Consumer takes a byte when reply_valid and reply_ready are high
// Notes: Leading zeros suppressed; one subtract step per cycle

`timescale 1ns/1ps

module gma_dec_emit (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Launch
	input wire logic start,
	input wire logic [15:0] value,
	output logic busy,
	// Byte stream
	output logic [7:0] reply_data,
	output logic reply_valid,
	input wire logic reply_ready
);

	gma_pkg::gma_emit_state_type state_ff;
	logic [15:0] rem_ff;
	logic [2:0] pos_ff;
	logic [3:0] dig_ff;
	logic started_ff;
	logic [7:0] data_ff;
	logic [15:0] pow;
	logic take_digit;
	logic emit_digit;

	// ----------
	// Digit weight and step decisions
	// ----------
	always_comb begin
		case (pos_ff)
			3'h4: pow = gma_pkg::DEC_POW4;
			3'h3: pow = gma_pkg::DEC_POW3;
			3'h2: pow = gma_pkg::DEC_POW2;
			3'h1: pow = gma_pkg::DEC_POW1;
			default: pow = gma_pkg::DEC_POW0;
		endcase
		take_digit = (rem_ff >= pow);
		emit_digit = (dig_ff != 4'h0) || started_ff || (pos_ff == 3'h0);
	end

	assign busy = (state_ff != gma_pkg::GMA_EM_IDLE);
	assign reply_valid = (state_ff == gma_pkg::GMA_EM_SEND) || (state_ff == gma_pkg::GMA_EM_TERM);
	assign reply_data = data_ff;

	// ----------
	// Sequencer
	// ----------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_ff <= gma_pkg::GMA_EM_IDLE;
		end else begin
			case (state_ff)
				gma_pkg::GMA_EM_IDLE: begin
					if (start) begin
						state_ff <= gma_pkg::GMA_EM_DIV;
					end
				end
				gma_pkg::GMA_EM_DIV: begin
					if (!take_digit && emit_digit) begin
						state_ff <= gma_pkg::GMA_EM_SEND;
					end
				end
				gma_pkg::GMA_EM_SEND: begin
					if (reply_ready) begin
						state_ff <= (pos_ff == 3'h0) ? gma_pkg::GMA_EM_TERM : gma_pkg::GMA_EM_DIV;
					end
				end
				gma_pkg::GMA_EM_TERM: begin
					if (reply_ready) begin
						state_ff <= gma_pkg::GMA_EM_IDLE;
					end
				end
				default: state_ff <= gma_pkg::GMA_EM_IDLE;
			endcase
		end
	end

	// ----------
	// Remainder, digit and output byte
	// ----------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rem_ff <= 16'h0000;
			pos_ff <= 3'h0;
			dig_ff <= 4'h0;
			started_ff <= 1'b0;
			data_ff <= 8'h00;
		end else begin
			case (state_ff)
				gma_pkg::GMA_EM_IDLE: begin
					if (start) begin
						rem_ff <= value;
						pos_ff <= gma_pkg::DEC_TOP_POS;
						dig_ff <= 4'h0;
						started_ff <= 1'b0;
					end
				end
				gma_pkg::GMA_EM_DIV: begin
					if (take_digit) begin
						rem_ff <= rem_ff - pow;
						dig_ff <= dig_ff + 4'h1;
					end else if (emit_digit) begin
						data_ff <= gma_pkg::ASCII_ZERO | {4'h0, dig_ff};
						started_ff <= 1'b1;
					end else begin
						pos_ff <= pos_ff - 3'h1;
					end
				end
				gma_pkg::GMA_EM_SEND: begin
					if (reply_ready) begin
						if (pos_ff == 3'h0) begin
							data_ff <= gma_pkg::REPLY_TERM;
						end else begin
							pos_ff <= pos_ff - 3'h1;
							dig_ff <= 4'h0;
						end
					end
				end
				default: begin
					rem_ff <= rem_ff;
				end
			endcase
		end
	end

endmodule

// File: gma_allocator.sv
// Purpose: Partitions graphics memory among five buffers and answers size queries
// Assumes: All inputs come from logic on sys_clk; host obeys its own pacing
// Notes: Sizes in bytes; buffer order physical, polygon, glyph, replot, vector

`timescale 1ns/1ps

module gma_allocator (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Allocate and graphics memory commands
	input wire logic alloc_req,
	input wire logic gmem_req,
	input wire logic [15:0] req_phys,
	input wire logic [15:0] req_poly,
	input wire logic [15:0] req_glyph,
	input wire logic [15:0] req_replot,
	input wire logic [15:0] req_vec,
	input wire logic glyph_defs_used,
	output logic alloc_busy,
	// Buffer control toward the datapath
	input wire logic in_buf_empty,
	input wire logic vec_buf_empty,
	output logic in_buf_flush,
	output logic clear_buffers,
	output logic parser_reset,
	// Committed partition
	output logic [15:0] alloc_phys,
	output logic [15:0] alloc_poly,
	output logic [15:0] alloc_glyph,
	output logic [15:0] alloc_replot,
	output logic [15:0] alloc_vec,
	output logic [15:0] logical_size,
	// Configuration command (logical size only)
	input wire logic cfg_req,
	input wire logic [15:0] cfg_logical,
	// Space check from instruction execution
	input wire logic need_req,
	input wire logic [2:0] need_sel,
	input wire logic [15:0] need_bytes,
	output logic need_ok,
	output logic err_valid,
	output logic [3:0] err_code,
	output logic [4:0] discard_buf,
	// Status
	output logic [7:0] ext_status,
	// Empty-size query and reply stream
	input wire logic esq_req,
	output logic [7:0] reply_data,
	output logic reply_valid,
	input wire logic reply_ready
);

	gma_pkg::gma_alloc_state_type state_ff;
	logic [15:0] work_ff [gma_pkg::NBUF];
	logic [15:0] size_ff [gma_pkg::NBUF];
	logic [gma_pkg::NBUF-1:0] done_ff;
	logic glyph_used_ff;
	logic [15:0] log_ff;
	logic esq_pend_ff;
	logic need_ok_ff;
	logic err_valid_ff;
	logic [3:0] err_code_ff;
	logic [4:0] discard_ff;
	logic [7:0] status_ff;
	logic [15:0] req_vals [gma_pkg::NBUF];
	logic [15:0] req_fit [gma_pkg::NBUF];
	logic [gma_pkg::SUM_W-1:0] sum;
	logic [gma_pkg::SUM_W-1:0] total_w;
	logic [15:0] excess;
	logic [15:0] deficit;
	logic pick_found;
	logic [2:0] pick_idx;
	logic [15:0] pick_val;
	logic [15:0] pick_room;
	logic [15:0] cut;
	logic esq_launch;
	logic emit_busy;
	logic [15:0] nxt_log;
	logic [15:0] cfg_fit;

	// ----------
	// Buffer minimum lookup
	// ----------
	function automatic logic [15:0] gma_min_of(input logic [2:0] idx, input logic glyph_used);
		case (idx)
			gma_pkg::BUF_PHYS: gma_min_of = gma_pkg::MIN_PHYS;
			gma_pkg::BUF_POLY: gma_min_of = gma_pkg::MIN_POLY;
			gma_pkg::BUF_GLYPH: gma_min_of = glyph_used ? gma_pkg::MIN_GLYPH_USED : gma_pkg::MIN_GLYPH_NONE;
			gma_pkg::BUF_REPLOT: gma_min_of = gma_pkg::MIN_REPLOT;
			default: gma_min_of = gma_pkg::MIN_VEC;
		endcase
	endfunction

	// ----------
	// Request shaping: even count, then minimum
	// ----------
	always_comb begin
		req_vals[0] = req_phys;
		req_vals[1] = req_poly;
		req_vals[2] = req_glyph;
		req_vals[3] = req_replot;
		req_vals[4] = req_vec;
		for (int i = 0; i < gma_pkg::NBUF; i++) begin
			req_fit[i] = req_vals[i] & 16'hFFFE;
			if (req_fit[i] < gma_min_of(3'(i), glyph_defs_used)) begin
				req_fit[i] = gma_min_of(3'(i), glyph_defs_used);
			end
		end
	end

	// ----------
	// Trim arithmetic: sum, excess, largest untouched request
	// ----------
	always_comb begin
		sum = '0;
		pick_found = 1'b0;
		pick_idx = 3'h0;
		pick_val = 16'h0000;
		for (int i = 0; i < gma_pkg::NBUF; i++) begin
			sum = sum + {3'h0, work_ff[i]};
			if (!done_ff[i] && (!pick_found || work_ff[i] > pick_val)) begin
				pick_found = 1'b1;
				pick_idx = 3'(i);
				pick_val = work_ff[i];
			end
		end
		total_w = {3'h0, gma_pkg::MEM_TOTAL};
		excess = (sum > total_w) ? 16'(sum - total_w) : 16'h0000;
		deficit = (sum < total_w) ? 16'(total_w - sum) : 16'h0000;
		pick_room = pick_val - gma_min_of(pick_idx, glyph_used_ff);
		cut = (excess < pick_room) ? excess : pick_room;
	end

	// ----------
	// Allocation sequencer
	// ----------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_ff <= gma_pkg::GMA_IDLE;
		end else begin
			case (state_ff)
				gma_pkg::GMA_IDLE: begin
					if (alloc_req) begin
						state_ff <= gma_pkg::GMA_FLUSH;
					end else if (gmem_req) begin
						state_ff <= gma_pkg::GMA_TRIM;
					end
				end
				gma_pkg::GMA_FLUSH: state_ff <= gma_pkg::GMA_WAIT_VEC;
				gma_pkg::GMA_WAIT_VEC: begin
					if (vec_buf_empty) begin
						state_ff <= gma_pkg::GMA_TRIM;
					end
				end
				gma_pkg::GMA_TRIM: begin
					if (excess == 16'h0000 || !pick_found) begin
						state_ff <= gma_pkg::GMA_CLEAR;
					end
				end
				gma_pkg::GMA_CLEAR: state_ff <= gma_pkg::GMA_PARSER_RST;
				gma_pkg::GMA_PARSER_RST: state_ff <= gma_pkg::GMA_IDLE;
				default: state_ff <= gma_pkg::GMA_IDLE;
			endcase
		end
	end

	assign in_buf_flush = (state_ff == gma_pkg::GMA_FLUSH);
	assign clear_buffers = (state_ff == gma_pkg::GMA_CLEAR);
	assign parser_reset = (state_ff == gma_pkg::GMA_PARSER_RST);
	assign alloc_busy = (state_ff != gma_pkg::GMA_IDLE);

	// ----------
	// Working request set and trim loop
	// ----------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < gma_pkg::NBUF; i++) begin
				work_ff[i] <= 16'h0000;
			end
			done_ff <= '0;
			glyph_used_ff <= 1'b0;
		end else if (state_ff == gma_pkg::GMA_IDLE && (alloc_req || gmem_req)) begin
			for (int i = 0; i < gma_pkg::NBUF; i++) begin
				work_ff[i] <= req_fit[i];
			end
			done_ff <= '0;
			glyph_used_ff <= glyph_defs_used;
		end else if (state_ff == gma_pkg::GMA_TRIM) begin
			if (excess != 16'h0000 && pick_found) begin
				work_ff[pick_idx] <= pick_val - cut;
				done_ff[pick_idx] <= 1'b1;
			end else if (deficit != 16'h0000) begin
				work_ff[gma_pkg::BUF_REPLOT] <= work_ff[gma_pkg::BUF_REPLOT] + deficit;
			end
		end
	end

	// ----------
	// Committed partition
	// ----------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			size_ff[0] <= gma_pkg::RST_PHYS;
			size_ff[1] <= gma_pkg::RST_POLY;
			size_ff[2] <= gma_pkg::RST_GLYPH;
			size_ff[3] <= gma_pkg::RST_REPLOT;
			size_ff[4] <= gma_pkg::RST_VEC;
		end else if (state_ff == gma_pkg::GMA_CLEAR) begin
			for (int i = 0; i < gma_pkg::NBUF; i++) begin
				size_ff[i] <= work_ff[i];
			end
		end
	end

	assign alloc_phys = size_ff[0];
	assign alloc_poly = size_ff[1];
	assign alloc_glyph = size_ff[2];
	assign alloc_replot = size_ff[3];
	assign alloc_vec = size_ff[4];

	// ----------
	// Logical input-buffer size
	// ----------
	always_comb begin
		if (cfg_logical == 16'h0000 || cfg_logical > size_ff[0]) begin
			cfg_fit = size_ff[0];
		end else if (cfg_logical < gma_pkg::LOG_MIN) begin
			cfg_fit = gma_pkg::LOG_MIN;
		end else begin
			cfg_fit = cfg_logical;
		end
		if (cfg_fit > gma_pkg::LOG_MAX) begin
			cfg_fit = gma_pkg::LOG_MAX;
		end
		nxt_log = log_ff;
		if (state_ff == gma_pkg::GMA_CLEAR) begin
			if (work_ff[0] < log_ff) begin
				nxt_log = work_ff[0];
			end
		end else if (cfg_req) begin
			nxt_log = cfg_fit;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			log_ff <= gma_pkg::LOG_RST;
		end else begin
			log_ff <= nxt_log;
		end
	end

	assign logical_size = log_ff;

	// ----------
	// Buffer space check and overflow handling
	// ----------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			need_ok_ff <= 1'b0;
			err_valid_ff <= 1'b0;
			err_code_ff <= gma_pkg::ERR_NONE;
			discard_ff <= 5'h00;
		end else begin
			need_ok_ff <= 1'b0;
			err_valid_ff <= 1'b0;
			discard_ff <= 5'h00;
			if (need_req && need_sel < 3'(gma_pkg::NBUF)) begin
				if (need_bytes > size_ff[need_sel]) begin
					err_valid_ff <= 1'b1;
					err_code_ff <= gma_pkg::ERR_OVERFLOW;
					discard_ff <= 5'h01 << need_sel;
				end else begin
					need_ok_ff <= 1'b1;
				end
			end
		end
	end

	assign need_ok = need_ok_ff;
	assign err_valid = err_valid_ff;
	assign err_code = err_code_ff;
	assign discard_buf = discard_ff;

	// ----------
	// Extended status word
	// ----------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			status_ff <= 8'h00;
		end else begin
			status_ff <= 8'h00;
			status_ff[gma_pkg::STAT_IN_EMPTY_BIT] <= in_buf_empty && !alloc_busy;
		end
	end

	assign ext_status = status_ff;

	// ----------
	// Empty-size query: hold until drained and allocation finished
	// ----------
	assign esq_launch = esq_pend_ff && in_buf_empty && !alloc_busy && !alloc_req && !gmem_req
		&& !emit_busy;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			esq_pend_ff <= 1'b0;
		end else begin
			esq_pend_ff <= (esq_pend_ff && !esq_launch) || esq_req;
		end
	end

	gma_dec_emit u_emit (
		.sys_clk(sys_clk),
		.reset(reset),
		.start(esq_launch),
		.value(log_ff),
		.busy(emit_busy),
		.reply_data(reply_data),
		.reply_valid(reply_valid),
		.reply_ready(reply_ready)
	);

endmodule

// File: gma_allocator_assertions.sv
// Purpose: Concurrent checks on the allocator ports
// Assumes: Single sys_clk domain, reset async active high
// Notes: Bound to gma_allocator from the testbench top file
`timescale 1ns/1ps

module gma_allocator_assertions (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Allocation sequence
	input wire logic alloc_req,
	input wire logic gmem_req,
	input wire logic alloc_busy,
	input wire logic in_buf_empty,
	input wire logic vec_buf_empty,
	input wire logic in_buf_flush,
	input wire logic clear_buffers,
	input wire logic parser_reset,
	// Partition
	input wire logic [15:0] alloc_phys,
	input wire logic [15:0] alloc_poly,
	input wire logic [15:0] alloc_glyph,
	input wire logic [15:0] alloc_replot,
	input wire logic [15:0] alloc_vec,
	input wire logic [15:0] logical_size,
	// Space check and status
	input wire logic need_req,
	input wire logic [2:0] need_sel,
	input wire logic need_ok,
	input wire logic err_valid,
	input wire logic [3:0] err_code,
	input wire logic [4:0] discard_buf,
	input wire logic [7:0] ext_status,
	// Reply stream
	input wire logic [7:0] reply_data,
	input wire logic reply_valid,
	input wire logic reply_ready
);
	logic [18:0] sum_w;
	logic odd_w;

	assign sum_w = 19'(alloc_phys) + 19'(alloc_poly) + 19'(alloc_glyph) + 19'(alloc_replot)
		+ 19'(alloc_vec);
	assign odd_w = alloc_phys[0] | alloc_poly[0] | alloc_glyph[0] | alloc_replot[0] | alloc_vec[0];

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	// ----------
	// Sequences
	// ----------
	sequence s_take_alloc;
		alloc_req && !alloc_busy;
	endsequence
	sequence s_flush_vec_ready;
		in_buf_flush ##1 vec_buf_empty;
	endsequence
	sequence s_tail;
		parser_reset ##1 !alloc_busy;
	endsequence

	// ----------
	// Properties
	// ----------
	AST_FLUSH_FIRST: assert property (s_take_alloc |=> in_buf_flush && alloc_busy)
		else $error("no flush after allocate");
	AST_GMEM_NO_FLUSH: assert property (
		gmem_req && !alloc_req && !alloc_busy |=> alloc_busy && !in_buf_flush)
		else $error("graphics memory command flushed input");
	AST_WAIT_VEC: assert property (
		in_buf_flush ##1 !vec_buf_empty |=> alloc_busy && !clear_buffers)
		else $error("clear before vector drain");
	AST_ALLOC_BOUND: assert property (s_flush_vec_ready |-> ##[2:8] clear_buffers)
		else $error("clear late after drain");
	AST_CLEAR_ORDER: assert property (clear_buffers |=> s_tail)
		else $error("parser reset not after clear");
	AST_SUM_TOTAL: assert property (
		parser_reset |-> sum_w == {3'h0, gma_pkg::MEM_TOTAL})
		else $error("partition sum wrong");
	AST_EVEN_MIN: assert property (
		parser_reset |-> !odd_w && alloc_vec >= gma_pkg::MIN_VEC && alloc_phys >= gma_pkg::MIN_PHYS)
		else $error("odd or undersized buffer");
	AST_LOGICAL_LE: assert property (parser_reset |-> logical_size <= alloc_phys)
		else $error("logical above physical");
	AST_OVERFLOW_CODE: assert property (
		err_valid |-> err_code == gma_pkg::ERR_OVERFLOW && $onehot(discard_buf))
		else $error("overflow code or discard wrong");
	AST_NEED_ANSWER: assert property (need_req && need_sel < 3'h5 |=> need_ok != err_valid)
		else $error("space check not answered");
	AST_STATUS_BIT: assert property (
		!$past(reset) |-> ext_status[3] == ($past(in_buf_empty) && !$past(alloc_busy)))
		else $error("empty status bit wrong");
	AST_REPLY_HOLD: assert property (
		reply_valid && !reply_ready |=> reply_valid && $stable(reply_data))
		else $error("reply byte dropped");
endmodule

// File: gma_host_model.sv
// Purpose: Host and buffer datapath model facing the allocator
// Assumes: Bench loads fill counts for one cycle
// Notes: Reply reads stall at random when slow is set
`timescale 1ns/1ps

module gma_host_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Bench control
	input wire logic [7:0] in_load,
	input wire logic [7:0] vec_load,
	input wire logic slow,
	// Allocator side
	input wire logic in_buf_flush,
	output logic in_buf_empty,
	output logic vec_buf_empty,
	output logic reply_ready
);
	logic [7:0] in_cnt_ff;
	logic [7:0] vec_cnt_ff;
	logic [31:0] rnd_ff;

	assign in_buf_empty = (in_cnt_ff == 8'h00);
	assign vec_buf_empty = (vec_cnt_ff == 8'h00);

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) in_cnt_ff <= 8'h00;
		else if (in_buf_flush) in_cnt_ff <= 8'h00;
		else if (in_load != 8'h00) in_cnt_ff <= in_load;
		else if (in_cnt_ff != 8'h00) in_cnt_ff <= in_cnt_ff - 8'h01;
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) vec_cnt_ff <= 8'h00;
		else if (vec_load != 8'h00) vec_cnt_ff <= vec_load;
		else if (vec_cnt_ff != 8'h00) vec_cnt_ff <= vec_cnt_ff - 8'h01;
	end

	// Host reads every reply byte, sometimes late
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rnd_ff <= 32'hcd9c_55bb;
			reply_ready <= 1'b0;
		end else begin
			rnd_ff <= {rnd_ff[30:0], rnd_ff[31] ^ rnd_ff[21] ^ rnd_ff[1] ^ rnd_ff[0]};
			reply_ready <= !slow || rnd_ff[0];
		end
	end
endmodule

// File: gma_allocator_tb.sv
// Purpose: Self-checking bench for the graphics memory allocator
// Assumes: Replies and space answers never share a cycle
// Notes: Partition results compared at each parser reset
`timescale 1ns/1ps

module gma_allocator_tb;
	logic sys_clk, reset, alloc_req, gmem_req, glyph_defs_used, cfg_req, need_req, esq_req, slow;
	logic [15:0] req_phys, req_poly, req_glyph, req_replot, req_vec, cfg_logical, need_bytes;
	logic [2:0] need_sel;
	logic [7:0] in_load, vec_load, ext_status, reply_data;
	logic alloc_busy, in_buf_empty, vec_buf_empty, in_buf_flush, clear_buffers, parser_reset;
	logic [15:0] alloc_phys, alloc_poly, alloc_glyph, alloc_replot, alloc_vec, logical_size;
	logic need_ok, err_valid, reply_valid, reply_ready;
	logic [3:0] err_code, m_code;
	logic [4:0] discard_buf;
	logic [31:0] ev_q [$];
	logic [95:0] al_q [$];
	logic [79:0] m_sz, r;
	logic [15:0] m_phys, m_log, v;
	logic [15:0] cfg_tab [4] = '{16'h1388, 16'h0001, 16'h0000, 16'h3000};
	logic [31:0] seed = 32'hcd9c_55bb;
	int miscompares, total_checks, rx_bad;

	gma_allocator gma_allocator_i (.sys_clk, .reset, .alloc_req, .gmem_req, .req_phys,
		.req_poly, .req_glyph, .req_replot, .req_vec, .glyph_defs_used, .alloc_busy, .in_buf_empty,
		.vec_buf_empty, .in_buf_flush, .clear_buffers, .parser_reset, .alloc_phys, .alloc_poly,
		.alloc_glyph, .alloc_replot, .alloc_vec, .logical_size, .cfg_req, .cfg_logical, .need_req,
		.need_sel, .need_bytes, .need_ok, .err_valid, .err_code, .discard_buf, .ext_status,
		.esq_req, .reply_data, .reply_valid, .reply_ready);
	gma_host_model gma_host_model_i (.sys_clk, .reset, .in_load, .vec_load, .slow, .in_buf_flush,
		.in_buf_empty, .vec_buf_empty, .reply_ready);

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// ----------
	// Helpers
	// ----------
	task automatic check(input logic [95:0] seen, input logic [95:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic pop_ev(input logic [31:0] seen);
		check({64'h0, seen}, {64'h0, (ev_q.size() > 0) ? ev_q.pop_front() : 32'h0000_0000});
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [95:0] ref_alloc(input logic [79:0] q, input logic u, input logic [15:0] lg);
		int s [5];
		int mn [5];
		bit cut [5];
		int ex;
		int b;
		int k;
		mn = '{gma_pkg::MIN_PHYS, gma_pkg::MIN_POLY,
			u ? gma_pkg::MIN_GLYPH_USED : gma_pkg::MIN_GLYPH_NONE, gma_pkg::MIN_REPLOT, gma_pkg::MIN_VEC};
		cut = '{default: 0};
		ex = -int'(gma_pkg::MEM_TOTAL);
		for (int i = 0; i < 5; i++) begin
			s[i] = int'(q[79 - 16 * i -: 16] & 16'hfffe);
			if (s[i] < mn[i]) s[i] = mn[i];
			ex += s[i];
		end
		while (ex > 0) begin
			b = -1;
			for (int i = 0; i < 5; i++) if (!cut[i] && (b < 0 || s[i] > s[b])) b = i;
			cut[b] = 1;
			k = (ex < s[b] - mn[b]) ? ex : s[b] - mn[b];
			s[b] -= k;
			ex -= k;
		end
		s[3] -= ex;
		if (s[0] < lg) lg = 16'(s[0]);
		return {16'(s[0]), 16'(s[1]), 16'(s[2]), 16'(s[3]), 16'(s[4]), lg};
	endfunction

	task automatic wait_until(input bit for_reply);
		for (int i = 0; i < 3000; i++) begin
			@(posedge sys_clk);
			#1;
			if (for_reply ? ev_q.size() == 0 : alloc_busy === 1'b0) break;
		end
	endtask

	task automatic do_alloc(input logic [79:0] q, input logic u, input logic gmem);
		logic [95:0] e;
		e = ref_alloc(q, u, m_log);
		al_q.push_back(e);
		{m_sz, m_log} = e;
		m_phys = e[95:80];
		@(posedge sys_clk);
		{req_phys, req_poly, req_glyph, req_replot, req_vec} <= q;
		glyph_defs_used <= u;
		alloc_req <= !gmem;
		gmem_req <= gmem;
		@(posedge sys_clk);
		alloc_req <= 1'b0;
		gmem_req <= 1'b0;
		wait_until(1'b0);
	endtask

	task automatic do_query(input logic [15:0] x);
		string d;
		d = $sformatf("%0d", x);
		for (int i = 0; i < d.len(); i++) ev_q.push_back({24'h01_0000, d[i]});
		ev_q.push_back({24'h01_0000, gma_pkg::REPLY_TERM});
		@(posedge sys_clk);
		esq_req <= 1'b1;
		@(posedge sys_clk);
		esq_req <= 1'b0;
		wait_until(1'b1);
	endtask

	task automatic do_need(input logic [2:0] sel, input logic [15:0] b, input logic ok);
		if (!ok) m_code = gma_pkg::ERR_OVERFLOW;
		if (sel < 3'h5) ev_q.push_back({8'h02, 10'h000, ok, !ok, m_code, 3'h0, ok ? 5'h00 : 5'(1 << sel)});
		@(posedge sys_clk);
		need_req <= 1'b1;
		need_sel <= sel;
		need_bytes <= b;
		@(posedge sys_clk);
		need_req <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ----------
	// Result monitor
	// ----------
	always @(posedge sys_clk) begin
		if (reset === 1'b0) begin
			if (reply_valid && reply_ready) begin
				if (alloc_busy || !in_buf_empty) rx_bad++;
				pop_ev({24'h01_0000, reply_data});
			end
			if (need_ok || err_valid)
				pop_ev({8'h02, 10'h000, need_ok, err_valid, err_code, 3'h0, discard_buf});
			if (parser_reset)
				check({alloc_phys, alloc_poly, alloc_glyph, alloc_replot, alloc_vec, logical_size},
					(al_q.size() > 0) ? al_q.pop_front() : 96'h0);
		end
	end

	initial begin
		repeat (60000) @(posedge sys_clk);
		miscompares++;
		report_and_stop();
	end

	// ----------
	// Tests
	// ----------
	initial begin
		{alloc_req, gmem_req, glyph_defs_used, cfg_req, need_req, esq_req, slow, need_sel} = '0;
		{req_phys, req_poly, req_glyph, req_replot, req_vec, cfg_logical, need_bytes} = '0;
		{in_load, vec_load, miscompares, total_checks, rx_bad} = '0;
		m_code = gma_pkg::ERR_NONE;
		reset = 1'b1;
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		#1;
		m_sz = {gma_pkg::RST_PHYS, gma_pkg::RST_POLY, gma_pkg::RST_GLYPH, gma_pkg::RST_REPLOT,
			gma_pkg::RST_VEC};
		m_log = gma_pkg::LOG_RST;
		m_phys = gma_pkg::RST_PHYS;
		check({alloc_phys, alloc_poly, alloc_glyph, alloc_replot, alloc_vec}, m_sz);
		check({err_code, logical_size}, {m_code, 16'h0400});
		slow <= 1'b1;
		do_query(16'h0400);
		$display("test reset done");
		do_alloc({16'h1b70, 16'h1b8a, 16'h1ba4, 16'h0000, 16'h0064}, 1'b0, 1'b0);
		check(m_sz, {16'h1b70, 16'h162c, 16'h0000, 16'h0000, 16'h0064});
		for (int i = 0; i < 5; i++) begin
			do_need(3'(i), m_sz[79 - 16 * i -: 16], 1'b1);
			do_need(3'(i), m_sz[79 - 16 * i -: 16] + 16'h0002, 1'b0);
		end
		do_need(3'h5, 16'h0000, 1'b1);
		$display("test trim and overflow done");
		foreach (cfg_tab[i]) begin
			v = (cfg_tab[i] == 16'h0001) ? 16'h0002 : cfg_tab[i];
			if (v == 16'h0000 || v > m_phys) v = m_phys;
			if (v > gma_pkg::LOG_MAX) v = gma_pkg::LOG_MAX;
			m_log = v;
			@(posedge sys_clk);
			cfg_req <= 1'b1;
			cfg_logical <= cfg_tab[i];
			@(posedge sys_clk);
			cfg_req <= 1'b0;
			do_query(v);
		end
		do_alloc({16'h1b70, 16'h1b8a, 16'h1ba4, 16'h0000, 16'h0064}, 1'b1, 1'b1);
		do_alloc({16'h0001, 16'h0091, 16'h000a, 16'h0000, 16'h0003}, 1'b1, 1'b0);
		do_query(m_log);
		$display("test shaping done");
		for (int n = 0; n < 6; n++) begin
			for (int j = 0; j < 5; j++) begin
				seed = lfsr(seed);
				r[16 * j +: 16] = {3'h0, seed[12:0]};
			end
			seed = lfsr(seed);
			@(posedge sys_clk);
			in_load <= seed[7:0];
			vec_load <= seed[15:8];
			slow <= seed[16];
			@(posedge sys_clk);
			{in_load, vec_load} <= 16'h0000;
			do_alloc(r, seed[17], seed[18]);
		end
		do_query(m_log);
		$display("test random allocation done");
		@(posedge sys_clk);
		{in_load, vec_load} <= 16'h2830;
		@(posedge sys_clk);
		{in_load, vec_load} <= 16'h0000;
		fork
			do_alloc({16'h0800, 16'h0100, 16'h0000, 16'h1000, 16'h0100}, 1'b0, 1'b0);
			begin
				repeat (3) @(posedge sys_clk);
				do_query(m_log);
			end
		join
		@(posedge sys_clk);
		in_load <= 8'h40;
		@(posedge sys_clk);
		in_load <= 8'h00;
		repeat (3) @(posedge sys_clk);
		#1;
		check(ext_status, 8'h00);
		do_query(m_log);
		repeat (3) @(posedge sys_clk);
		#1;
		check(ext_status, 8'h08);
		check(rx_bad, 0);
		check(al_q.size() + ev_q.size(), 0);
		$display("test held replies done");
		report_and_stop();
	end
endmodule

bind gma_allocator gma_allocator_assertions gma_allocator_assertions_i (.sys_clk, .reset,
	.alloc_req, .gmem_req, .alloc_busy, .in_buf_empty, .vec_buf_empty, .in_buf_flush,
	.clear_buffers, .parser_reset, .alloc_phys, .alloc_poly, .alloc_glyph, .alloc_replot,
	.alloc_vec, .logical_size, .need_req, .need_sel, .need_ok, .err_valid, .err_code,
	.discard_buf, .ext_status, .reply_data, .reply_valid, .reply_ready);
